// ### rtl/pioc_cfg.svh
// What this block does
// - registers 32 bits, bit n is line n
// - absent lines ignore writes, read zero
// - unmultiplexed lines always owned, read one
// - own enable write one takes pin
// - own disable write one gives pin away
// - own status: one controller, zero peripheral
// - own status reset value is per product
// - drive enable write one enables driver
// - drive disable write one disables driver
// - drive status resets zero, one means output
// - filter enable, disable, status resets zero
// - level set, clear, status resets zero
// - direct level write only where sync enabled
// - pin level register follows actual lines
// - change flags reset zero, then capture changes
// - pull-up disable, enable, status resets zero
// - select first clears, second sets status
// - sync write enable, disable, status resets zero
// - set and clear writes change driven level
// - one direct write updates enabled bits together
// - irq enable, disable change the mask
// - reading change flags clears all but changes in the same cycle
`ifndef PIOC_CFG_SVH
`define PIOC_CFG_SVH
`define PIOC_OWN_EN 8'h00
`define PIOC_OWN_DIS 8'h04
`define PIOC_OWN_ST 8'h08
`define PIOC_DRV_EN 8'h10
`define PIOC_DRV_DIS 8'h14
`define PIOC_DRV_ST 8'h18
`define PIOC_FLT_EN 8'h20
`define PIOC_FLT_DIS 8'h24
`define PIOC_FLT_ST 8'h28
`define PIOC_LVL_SET 8'h30
`define PIOC_LVL_CLR 8'h34
`define PIOC_LVL_ST 8'h38
`define PIOC_PIN_LVL 8'h3c
`define PIOC_IRQ_EN 8'h40
`define PIOC_IRQ_DIS 8'h44
`define PIOC_IRQ_MASK 8'h48
`define PIOC_IRQ_FLAGS 8'h4c
`define PIOC_OD_EN 8'h50
`define PIOC_OD_DIS 8'h54
`define PIOC_OD_ST 8'h58
`define PIOC_PU_DIS 8'h60
`define PIOC_PU_EN 8'h64
`define PIOC_PU_ST 8'h68
`define PIOC_SEL_A 8'h70
`define PIOC_SEL_B 8'h74
`define PIOC_SEL_ST 8'h78
`define PIOC_SW_EN 8'ha0
`define PIOC_SW_DIS 8'ha4
`define PIOC_SW_ST 8'ha8
`define PIOC_ZERO 32'h00000000
`endif

// ### rtl/pioc_pkg.sv
package pioc_pkg;
    typedef logic [31:0] pioc_word_t;
    typedef enum logic [0:0] {
        PIOC_IDLE = 1'b0,
        PIOC_ACK = 1'b1
    } pioc_bus_t;
endpackage : pioc_pkg

// ### rtl/pioc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pioc_cfg.svh"
module pioc_top #(
    parameter logic [31:0] LINE_MASK = 32'hffffffff,
    parameter logic [31:0] MUX_MASK = 32'hffffffff,
    parameter logic [31:0] OWN_RESET = 32'hffffffff
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] lineIn,
    output logic [31:0] lineOut,
    output logic [31:0] lineOe,
    output logic [31:0] pullupOn,
    output logic [31:0] periphOwn,
    output logic [31:0] periphSel,
    output logic [31:0] openDrain
);
    pioc_pkg::pioc_word_t own, drv, flt, lvl, mask, flags, od, pu, sel, sw;
    pioc_pkg::pioc_word_t next_own, next_drv, next_flt, next_lvl, next_mask;
    pioc_pkg::pioc_word_t next_flags, next_od, next_pu, next_sel, next_sw;
    pioc_pkg::pioc_word_t rawQ, fltQ, pinLvl, next_pinLvl, rdData;
    pioc_pkg::pioc_word_t next_lineOut, next_lineOe, wdata, chg;
    pioc_pkg::pioc_bus_t busSt, next_busSt;
    logic wrStb, rdStb;

    // set-then-clear update; a set and clear in one cycle never happen
    function automatic pioc_pkg::pioc_word_t setClr(
        input pioc_pkg::pioc_word_t cur,
        input logic doSet,
        input logic doClr,
        input pioc_pkg::pioc_word_t d);
        pioc_pkg::pioc_word_t r;
        r = cur;
        if (doSet) r = r | d;
        if (doClr) r = r & ~d;
        return r;
    endfunction : setClr

    function automatic pioc_pkg::pioc_word_t byteMask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : byteMask

    // one access per request; ack drops the cycle after
    always_comb begin
        next_busSt = pioc_pkg::PIOC_IDLE;
        if (busSt == pioc_pkg::PIOC_IDLE && wb_cyc_i && wb_stb_i)
            next_busSt = pioc_pkg::PIOC_ACK;
    end
    assign wrStb = (busSt == pioc_pkg::PIOC_IDLE) && wb_cyc_i && wb_stb_i
                   && wb_we_i;
    assign rdStb = (busSt == pioc_pkg::PIOC_IDLE) && wb_cyc_i && wb_stb_i
                   && !wb_we_i;
    // only lines that exist take writes
    assign wdata = wb_dat_i & byteMask(wb_sel_i) & LINE_MASK;

    // filtered view: a line with filter on must hold two samples
    always_comb begin
        next_pinLvl = pinLvl;
        for (int i = 0; i < 32; i++) begin
            if (!flt[i] || rawQ[i] == fltQ[i])
                next_pinLvl[i] = rawQ[i];
        end
        next_pinLvl = next_pinLvl & LINE_MASK;
    end
    assign chg = (next_pinLvl ^ pinLvl) & LINE_MASK;

    always_comb begin
        next_own = own;
        next_drv = drv;
        next_flt = flt;
        next_lvl = lvl;
        next_mask = mask;
        next_od = od;
        next_pu = pu;
        next_sel = sel;
        next_sw = sw;
        next_flags = flags;
        if (wrStb) begin
            case (wb_adr_i)
                `PIOC_OWN_EN: next_own = own | wdata;
                `PIOC_OWN_DIS: next_own = own & ~wdata;
                `PIOC_DRV_EN: next_drv = setClr(drv, 1'b1, 1'b0, wdata);
                `PIOC_DRV_DIS: next_drv = setClr(drv, 1'b0, 1'b1, wdata);
                `PIOC_FLT_EN: next_flt = setClr(flt, 1'b1, 1'b0, wdata);
                `PIOC_FLT_DIS: next_flt = setClr(flt, 1'b0, 1'b1, wdata);
                `PIOC_LVL_SET: next_lvl = setClr(lvl, 1'b1, 1'b0, wdata);
                `PIOC_LVL_CLR: next_lvl = setClr(lvl, 1'b0, 1'b1, wdata);
                // all enabled bits land in the same edge
                `PIOC_LVL_ST: next_lvl = (lvl & ~sw) | (wdata & sw);
                `PIOC_IRQ_EN: next_mask = setClr(mask, 1'b1, 1'b0, wdata);
                `PIOC_IRQ_DIS: next_mask = setClr(mask, 1'b0, 1'b1, wdata);
                `PIOC_OD_EN: next_od = setClr(od, 1'b1, 1'b0, wdata);
                `PIOC_OD_DIS: next_od = setClr(od, 1'b0, 1'b1, wdata);
                `PIOC_PU_DIS: next_pu = setClr(pu, 1'b0, 1'b1, wdata);
                `PIOC_PU_EN: next_pu = setClr(pu, 1'b1, 1'b0, wdata);
                `PIOC_SEL_A: next_sel = setClr(sel, 1'b0, 1'b1, wdata);
                `PIOC_SEL_B: next_sel = setClr(sel, 1'b1, 1'b0, wdata);
                `PIOC_SW_EN: next_sw = setClr(sw, 1'b1, 1'b0, wdata);
                `PIOC_SW_DIS: next_sw = setClr(sw, 1'b0, 1'b1, wdata);
                default: next_own = own;
            endcase
        end
        // unmuxed lines stay with the controller
        next_own = next_own | ~MUX_MASK;
        // read clears, but a change in the same cycle survives
        if (rdStb && wb_adr_i == `PIOC_IRQ_FLAGS)
            next_flags = `PIOC_ZERO;
        next_flags = (next_flags | chg) & LINE_MASK;
        // pad driven only when the controller owns it
        next_lineOut = next_lvl;
        next_lineOe = next_drv & next_own & ~(next_od & next_lvl);
    end

    always_comb begin
        case (wb_adr_i)
            `PIOC_OWN_ST: rdData = own;
            `PIOC_DRV_ST: rdData = drv;
            `PIOC_FLT_ST: rdData = flt;
            `PIOC_LVL_ST: rdData = lvl;
            `PIOC_PIN_LVL: rdData = pinLvl;
            `PIOC_IRQ_MASK: rdData = mask;
            `PIOC_IRQ_FLAGS: rdData = flags;
            `PIOC_OD_ST: rdData = od;
            `PIOC_PU_ST: rdData = pu;
            `PIOC_SEL_ST: rdData = sel;
            `PIOC_SW_ST: rdData = sw;
            default: rdData = `PIOC_ZERO;
        endcase
        rdData = rdData & LINE_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            busSt <= pioc_pkg::PIOC_IDLE;
            own <= OWN_RESET | ~MUX_MASK;
            drv <= `PIOC_ZERO;
            flt <= `PIOC_ZERO;
            lvl <= `PIOC_ZERO;
            mask <= `PIOC_ZERO;
            flags <= `PIOC_ZERO;
            od <= `PIOC_ZERO;
            pu <= `PIOC_ZERO;
            sel <= `PIOC_ZERO;
            sw <= `PIOC_ZERO;
            rawQ <= `PIOC_ZERO;
            fltQ <= `PIOC_ZERO;
            pinLvl <= `PIOC_ZERO;
            wb_ack_o <= 1'b0;
            wb_dat_o <= `PIOC_ZERO;
            lineOut <= `PIOC_ZERO;
            lineOe <= `PIOC_ZERO;
            pullupOn <= `PIOC_ZERO;
            periphOwn <= `PIOC_ZERO;
            periphSel <= `PIOC_ZERO;
            openDrain <= `PIOC_ZERO;
        end else begin
            busSt <= next_busSt;
            own <= next_own;
            drv <= next_drv;
            flt <= next_flt;
            lvl <= next_lvl;
            mask <= next_mask;
            flags <= next_flags;
            od <= next_od;
            pu <= next_pu;
            sel <= next_sel;
            sw <= next_sw;
            rawQ <= lineIn;
            fltQ <= rawQ;
            pinLvl <= next_pinLvl;
            wb_ack_o <= (next_busSt == pioc_pkg::PIOC_ACK);
            wb_dat_o <= rdStb ? rdData : `PIOC_ZERO;
            lineOut <= next_lineOut & LINE_MASK;
            lineOe <= next_lineOe & LINE_MASK;
            pullupOn <= next_pu & LINE_MASK;
            periphOwn <= ~next_own & LINE_MASK;
            periphSel <= next_sel & LINE_MASK;
            openDrain <= next_od & LINE_MASK;
        end
    end

    a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_own_enable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_OWN_EN |=> (own & $past(wdata)) == $past(wdata))
        else $error("own enable failed");
    a_own_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_OWN_DIS |=>
        (own & $past(wdata) & MUX_MASK) == `PIOC_ZERO)
        else $error("own disable failed");
    a_unmux_owned: assert property (@(posedge core_clk) disable iff (!rstn)
        (own & ~MUX_MASK) == ~MUX_MASK)
        else $error("unmuxed line not owned");
    a_drv_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_DRV_DIS |=> (drv & $past(wdata)) == 32'h0)
        else $error("driver disable failed");
    a_direct_lvl: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_LVL_ST |=>
        ((lvl ^ $past(lvl)) & ~$past(sw)) == 32'h0)
        else $error("direct write hit masked bit");
    a_flags_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        rdStb && wb_adr_i == `PIOC_IRQ_FLAGS |=> flags == $past(chg))
        else $error("flags not cleared on read");
    a_change_flag: assert property (@(posedge core_clk) disable iff (!rstn)
        chg != 32'h0 |=> (flags & $past(chg)) == $past(chg))
        else $error("change lost");
    a_absent_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        wb_ack_o |-> (wb_dat_o & ~LINE_MASK) == 32'h0)
        else $error("absent line reads one");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        rdStb && wb_adr_i == 8'h0c |=> wb_dat_o == 32'h0)
        else $error("reserved offset not zero");
    a_oe_owned: assert property (@(posedge core_clk) disable iff (!rstn)
        (lineOe & ~own & LINE_MASK) == 32'h0)
        else $error("driver on peripheral pin");

    // one property per set/clear register, so a miswired case item shows
    a_drv_enable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_DRV_EN |=> (drv & $past(wdata)) == $past(wdata))
        else $error("driver enable failed");
    a_flt_enable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_FLT_EN |=> (flt & $past(wdata)) == $past(wdata))
        else $error("filter enable failed");
    a_flt_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_FLT_DIS |=> (flt & $past(wdata)) == 32'h0)
        else $error("filter disable failed");
    a_lvl_set: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_LVL_SET |=> (lvl & $past(wdata)) == $past(wdata))
        else $error("level set failed");
    a_lvl_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_LVL_CLR |=> (lvl & $past(wdata)) == 32'h0)
        else $error("level clear failed");
    a_lvl_direct_in: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_LVL_ST |=>
        (lvl & $past(sw)) == ($past(wdata) & $past(sw)))
        else $error("direct write missed enabled bit");
    a_mask_enable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_IRQ_EN |=> (mask & $past(wdata)) == $past(wdata))
        else $error("mask enable failed");
    a_mask_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_IRQ_DIS |=> (mask & $past(wdata)) == 32'h0)
        else $error("mask disable failed");
    a_pu_enable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_PU_EN |=> (pu & $past(wdata)) == $past(wdata))
        else $error("pull-up enable failed");
    a_pu_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_PU_DIS |=> (pu & $past(wdata)) == 32'h0)
        else $error("pull-up disable failed");
    a_sel_first: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_SEL_A |=> (sel & $past(wdata)) == 32'h0)
        else $error("first select failed");
    a_sel_second: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_SEL_B |=> (sel & $past(wdata)) == $past(wdata))
        else $error("second select failed");
    a_sw_enable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_SW_EN |=> (sw & $past(wdata)) == $past(wdata))
        else $error("sync write enable failed");
    a_sw_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_SW_DIS |=> (sw & $past(wdata)) == 32'h0)
        else $error("sync write disable failed");
    a_od_enable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_OD_EN |=> (od & $past(wdata)) == $past(wdata))
        else $error("open drain enable failed");
    a_od_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_OD_DIS |=> (od & $past(wdata)) == 32'h0)
        else $error("open drain disable failed");

    // writes to status offsets other than level status must leave the state alone
    a_ro_own: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_OWN_ST |=> own == $past(own))
        else $error("own status written");
    a_ro_drv: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_DRV_ST |=> drv == $past(drv))
        else $error("driver status written");
    a_ro_flt: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_FLT_ST |=> flt == $past(flt))
        else $error("filter status written");
    a_ro_mask: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_IRQ_MASK |=> mask == $past(mask))
        else $error("mask status written");
    a_ro_pu: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_PU_ST |=> pu == $past(pu))
        else $error("pull-up status written");
    a_ro_sel: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_SEL_ST |=> sel == $past(sel))
        else $error("select status written");
    a_ro_sw: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb && wb_adr_i == `PIOC_SW_ST |=> sw == $past(sw))
        else $error("sync write status written");
    a_absent_state: assert property (@(posedge core_clk) disable iff (!rstn)
        ((drv | flt | lvl | mask | flags | od | pu | sel | sw) & ~LINE_MASK)
        == 32'h0)
        else $error("absent line holds state");

    a_ack_follows: assert property (@(posedge core_clk) disable iff (!rstn)
        wrStb || rdStb |=> wb_ack_o)
        else $error("request not answered");
    a_dat_idle_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_own_read: assert property (@(posedge core_clk) disable iff (!rstn)
        rdStb && wb_adr_i == `PIOC_OWN_ST |=> wb_dat_o == ($past(own) & LINE_MASK))
        else $error("own status read wrong");
    a_drv_read: assert property (@(posedge core_clk) disable iff (!rstn)
        rdStb && wb_adr_i == `PIOC_DRV_ST |=> wb_dat_o == $past(drv))
        else $error("driver status read wrong");
    a_lvl_read: assert property (@(posedge core_clk) disable iff (!rstn)
        rdStb && wb_adr_i == `PIOC_LVL_ST |=> wb_dat_o == $past(lvl))
        else $error("level status read wrong");
    a_pin_read: assert property (@(posedge core_clk) disable iff (!rstn)
        rdStb && wb_adr_i == `PIOC_PIN_LVL |=> wb_dat_o == $past(pinLvl))
        else $error("pin level read wrong");
    a_flags_read: assert property (@(posedge core_clk) disable iff (!rstn)
        rdStb && wb_adr_i == `PIOC_IRQ_FLAGS |=> wb_dat_o == $past(flags))
        else $error("change flags read wrong");
    a_flags_kept: assert property (@(posedge core_clk) disable iff (!rstn)
        !(rdStb && wb_adr_i == `PIOC_IRQ_FLAGS) |=>
        (flags & $past(flags)) == $past(flags))
        else $error("flag lost without read");

    // pad outputs are registered from the state; periphOwn is inverted own, lineOe is gated
    a_out_follows: assert property (@(posedge core_clk) disable iff (!rstn)
        lineOut == (lvl & LINE_MASK))
        else $error("driven level differs");
    a_periph_own: assert property (@(posedge core_clk) disable iff (!rstn)
        periphOwn == (~own & LINE_MASK))
        else $error("peripheral ownership differs");
    a_pull_copy: assert property (@(posedge core_clk) disable iff (!rstn)
        pullupOn == pu)
        else $error("pull-up output differs");
    a_sel_copy: assert property (@(posedge core_clk) disable iff (!rstn)
        periphSel == sel)
        else $error("select output differs");
    a_od_release: assert property (@(posedge core_clk) disable iff (!rstn)
        (lineOe & od & lvl) == 32'h0)
        else $error("open drain drives high");

    c_read_flags: cover property (@(posedge core_clk)
        rdStb && wb_adr_i == `PIOC_IRQ_FLAGS && flags != 32'h0);
    c_direct_write: cover property (@(posedge core_clk)
        wrStb && wb_adr_i == `PIOC_LVL_ST && sw != 32'h0);
    c_periph_b: cover property (@(posedge core_clk) sel != 32'h0);
    c_filter_change: cover property (@(posedge core_clk)
        flt != 32'h0 && chg != 32'h0);
    c_open_drain: cover property (@(posedge core_clk) (od & lvl) != 32'h0);
endmodule : pioc_top
`default_nettype wire

// ### verif/parallel_io_register_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pioc_cfg.svh"
module parallel_io_register_interface_test;
    localparam logic [31:0] LMASK = 32'h7fffffff;
    localparam logic [31:0] XMASK = 32'h0000ffff;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'hf;
    logic [31:0] wbDatW = 32'h00000000;
    logic [31:0] extDrv = 32'h00000000, extVal = 32'h00000000;
    logic [31:0] wbDatR, lineIn, lineOut, lineOe, pullupOn;
    logic [31:0] periphOwn, periphSel, openDrain;
    logic wbAck;
    int error_cnt = 0, n_compared = 0;
    pioc_pkg::pioc_word_t rd;
    // set, clear and status offsets of the plain set/clear triples
    logic [7:0] setA [7] = '{`PIOC_DRV_EN, `PIOC_FLT_EN, `PIOC_IRQ_EN,
        `PIOC_OD_EN, `PIOC_PU_EN, `PIOC_SEL_B, `PIOC_SW_EN};
    logic [7:0] clrA [7] = '{`PIOC_DRV_DIS, `PIOC_FLT_DIS, `PIOC_IRQ_DIS,
        `PIOC_OD_DIS, `PIOC_PU_DIS, `PIOC_SEL_A, `PIOC_SW_DIS};
    logic [7:0] stA [7] = '{`PIOC_DRV_ST, `PIOC_FLT_ST, `PIOC_IRQ_MASK,
        `PIOC_OD_ST, `PIOC_PU_ST, `PIOC_SEL_ST, `PIOC_SW_ST};
    logic [7:0] rsvA [6] = '{8'h0c, 8'h1c, 8'h7c, 8'h9c, 8'hac, 8'hfc};

    always #50 core_clk = ~core_clk;

    pioc_top #(.LINE_MASK(LMASK), .MUX_MASK(XMASK),
        .OWN_RESET(32'hffffffff)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .lineIn(lineIn), .lineOut(lineOut),
        .lineOe(lineOe), .pullupOn(pullupOn), .periphOwn(periphOwn),
        .periphSel(periphSel), .openDrain(openDrain));
    pioc_pad_model i_pads (.core_clk(core_clk), .lineOut(lineOut),
        .lineOe(lineOe), .pullupOn(pullupOn), .extDrv(extDrv),
        .extVal(extVal), .lineIn(lineIn));

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            give_verdict();
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h00000000);
        check($sformatf("reg %h", a), rd, exp);
    endtask : rdc

    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        rdc(`PIOC_OWN_ST, LMASK);
        rdc(`PIOC_LVL_ST, 32'h00000000);
        for (int i = 0; i < 7; i++) begin
            rdc(stA[i], 32'h00000000);
            wr(setA[i], 32'ha5a5a5a5);
            wr(clrA[i], 32'h0000ff00);
            wr(setA[i], 32'h00000000);
            rdc(stA[i], 32'h25a500a5);
            check("pullupOn", pullupOn,
                (i == 4) ? 32'h25a500a5 : 32'h00000000);
            check("periphSel", periphSel,
                (i == 5) ? 32'h25a500a5 : 32'h00000000);
            check("openDrain", openDrain,
                (i == 3) ? 32'h25a500a5 : 32'h00000000);
            wr(stA[i], 32'hffffffff);
            rdc(stA[i], 32'h25a500a5);
            wr(clrA[i], 32'hffffffff);
            rdc(stA[i], 32'h00000000);
        end
        wr(`PIOC_OWN_DIS, 32'hffffffff);
        rdc(`PIOC_OWN_ST, LMASK & ~XMASK);
        check("periphOwn", periphOwn & LMASK, XMASK);
        wr(`PIOC_OWN_EN, 32'h0000000f);
        wr(`PIOC_OWN_EN, 32'h00000000);
        rdc(`PIOC_OWN_ST, 32'h7fff000f);
        wr(`PIOC_OWN_EN, 32'hffffffff);
        wr(`PIOC_LVL_SET, 32'h000000ff);
        wr(`PIOC_LVL_CLR, 32'h0000000f);
        rdc(`PIOC_LVL_ST, 32'h000000f0);
        check("lineOut", lineOut, 32'h000000f0);
        wr(`PIOC_LVL_ST, 32'h12345678);
        rdc(`PIOC_LVL_ST, 32'h000000f0);
        wr(`PIOC_SW_EN, 32'h0000ffff);
        wr(`PIOC_LVL_ST, 32'hffff5678);
        rdc(`PIOC_LVL_ST, 32'h00005678);
        check("lineOut", lineOut, 32'h00005678);
        wr(`PIOC_DRV_EN, 32'h000000ff);
        extDrv <= 32'h7fffff00;
        extVal <= 32'h12345600;
        repeat (4) @(posedge core_clk);
        rdc(`PIOC_PIN_LVL, 32'h12345678);
        check("lineOe", lineOe, 32'h000000ff);
        wb(1'b0, `PIOC_IRQ_FLAGS, 32'h00000000);
        repeat (4) @(posedge core_clk);
        rdc(`PIOC_IRQ_FLAGS, 32'h00000000);
        extVal <= 32'h12345700;
        repeat (4) @(posedge core_clk);
        rdc(`PIOC_IRQ_FLAGS, 32'h00000100);
        rdc(`PIOC_IRQ_FLAGS, 32'h00000000);
        wr(`PIOC_OD_EN, 32'h00000008);
        check("lineOe", lineOe, 32'h000000f7);
        check("openDrain", openDrain, 32'h00000008);
        for (int i = 0; i < 6; i++) begin
            wr(rsvA[i], 32'hffffffff);
            rdc(rsvA[i], 32'h00000000);
        end
        give_verdict();
    end
endmodule : parallel_io_register_interface_test
`default_nettype wire

// ### verif/pioc_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pioc_pad_model (
    input wire logic core_clk,
    input wire logic [31:0] lineOut,
    input wire logic [31:0] lineOe,
    input wire logic [31:0] pullupOn,
    input wire logic [31:0] extDrv,
    input wire logic [31:0] extVal,
    output logic [31:0] lineIn
);
    // undriven lines without pull-up wander, so no stale level can pass for a match
    logic [31:0] floatPat = 32'h00000000;
    always @(posedge core_clk) begin
        floatPat <= ~floatPat;
    end
    always_comb begin
        lineIn = (lineOe & lineOut) | (~lineOe & extDrv & extVal)
            | (~lineOe & ~extDrv & pullupOn)
            | (~lineOe & ~extDrv & ~pullupOn & floatPat);
    end
endmodule : pioc_pad_model
`default_nettype wire
